// *** rtl/mra_pkg.sv ***
// Purpose: shared types and constants for the region attribute and permission checker
// Assumes: one core clock, eight regions, all configuration on plain ports
// Notes:   no offsets exist; field positions below are for the fault cause byte only
// Notes on behaviour
// - deny access lacking required permission, raise fault
// - type 000, cb 00 strongly ordered; 01 device
// - type 000 with cache bit: normal write-through
// - type 001: 00 noncacheable, 11 write-back allocate
// - type 010 cb 00 nonshared device; don't-cares ignored
// - type top bit set: outer BB, inner AA
// - policy 00 nc, 01 wb-ra, 10 wt, 11 wb
// - rights 000 deny everything
// - rights 001 privileged only
// - 010 user read only; 011 full access
// - 100 reserved; 101 privileged read only
// - rights 110/111 read only for all
// - violation raises memory management fault toward core
// - record fault cause in cause register
// - shareability and policy reported, never change behaviour
// - overlapping regions: highest region number wins
// - disabled subregion with no other cover faults, except privileged access with the default map
package mra_pkg;
  localparam int unsigned NUM_REGIONS = 8;
  localparam int unsigned REGION_W    = 3;
  localparam int unsigned BASE_LSB    = 5;           // base is held in 32-byte units
  localparam logic [4:0]  SIZE_SUB_MIN = 5'h07;      // 256 bytes and up have subregions
  localparam logic [5:0]  SUB_SHIFT    = 6'h03;      // eight subregions per region

  // memory type codes
  typedef enum logic [1:0] {
    MRA_MT_STRONG   = 2'b00,
    MRA_MT_DEVICE   = 2'b01,
    MRA_MT_NORMAL   = 2'b10,
    MRA_MT_RESERVED = 2'b11
  } mra_mem_type_t;

  // cache policy codes for one level
  localparam logic [1:0] POL_NC     = 2'h0;
  localparam logic [1:0] POL_WB_RWA = 2'h1;
  localparam logic [1:0] POL_WT_NWA = 2'h2;
  localparam logic [1:0] POL_WB_NWA = 2'h3;

  // type extension codes
  localparam logic [2:0] TYP_BASE   = 3'h0;
  localparam logic [2:0] TYP_NORMAL = 3'h1;
  localparam logic [2:0] TYP_DEVICE = 3'h2;

  // access rights codes
  localparam logic [2:0] AR_NONE    = 3'h0;
  localparam logic [2:0] AR_PRIV_RW = 3'h1;
  localparam logic [2:0] AR_USER_RO = 3'h2;
  localparam logic [2:0] AR_FULL    = 3'h3;
  localparam logic [2:0] AR_RSVD    = 3'h4;
  localparam logic [2:0] AR_PRIV_RO = 3'h5;
  localparam logic [2:0] AR_RO_A    = 3'h6;
  localparam logic [2:0] AR_RO_B    = 3'h7;

  // fault cause byte
  localparam int unsigned CAUSE_W        = 8;
  localparam int unsigned CAUSE_FETCH    = 0;
  localparam int unsigned CAUSE_DATA     = 1;
  localparam int unsigned CAUSE_ADDR_VLD = 7;
  localparam logic [7:0]  CAUSE_RESET    = 8'h00;

  // one region's programmed settings
  typedef struct packed {
    logic        enable;
    logic [26:0] base;
    logic [4:0]  size;
    logic [7:0]  subregion_off_mask;
    logic [2:0]  type_ext_field;
    logic        share;
    logic        cache;
    logic        buff;
    logic [2:0]  access_rights_code;
    logic        no_fetch_flag;
  } mra_region_cfg_t;

  localparam mra_region_cfg_t REGION_RESET = '0;
endpackage

// *** rtl/mra_region_if.sv ***
// Purpose: carries one region's settings, the access and the verdict between modules
// Assumes: one instance per region
// Notes:   purely combinational signals
interface mra_region_if;
  mra_pkg::mra_region_cfg_t cfg;
  logic [31:0]              addr;
  logic                     write;
  logic                     priv;
  logic                     fetch;
  logic                     hit;
  logic                     allow;
  mra_pkg::mra_mem_type_t   mem_type;
  logic                     share;
  logic [1:0]               inner_pol;
  logic [1:0]               outer_pol;
  logic                     reserved;

  modport top  (output cfg, addr, write, priv, fetch,
                input  hit, allow, mem_type, share, inner_pol, outer_pol, reserved);
  modport eval (input  cfg, addr, write, priv, fetch,
                output hit, allow, mem_type, share, inner_pol, outer_pol, reserved);
endinterface

// *** rtl/mra_region_eval.sv ***
// Purpose: address match, attribute decode and permission verdict for one region
// Assumes: settings stable while an access is being judged
// Notes:   purely combinational; the top registers the outcome
module mra_region_eval (
  mra_region_if.eval rif  // one region's settings and the access
);
  logic [5:0]  span_sh;
  logic [32:0] span;
  logic [31:0] keep_mask;
  logic [31:0] sub_bits;
  logic        in_range;
  logic        sub_off;

  // match address against base and size, then drop disabled subregions
  always_comb begin
    span_sh   = {1'b0, rif.cfg.size} + 6'h01;
    span      = (33'h1 << span_sh) - 33'h1;
    keep_mask = ~span[31:0];
    in_range  = rif.cfg.enable &&
                ((rif.addr & keep_mask) ==
                 ({rif.cfg.base, {mra_pkg::BASE_LSB{1'b0}}} & keep_mask));
    sub_bits  = rif.addr >> (span_sh - mra_pkg::SUB_SHIFT);
    // small regions have no subregions, so their mask is not consulted
    sub_off   = (rif.cfg.size >= mra_pkg::SIZE_SUB_MIN) &&
                rif.cfg.subregion_off_mask[sub_bits[2:0]];
    rif.hit   = in_range && !sub_off;
  end

  // permission verdict
  always_comb begin
    case (rif.cfg.access_rights_code)
      mra_pkg::AR_NONE:    rif.allow = 1'b0;
      mra_pkg::AR_PRIV_RW: rif.allow = rif.priv;
      mra_pkg::AR_USER_RO: rif.allow = rif.priv || !rif.write;
      mra_pkg::AR_FULL:    rif.allow = 1'b1;
      mra_pkg::AR_RSVD:    rif.allow = 1'b0;
      mra_pkg::AR_PRIV_RO: rif.allow = rif.priv && !rif.write;
      mra_pkg::AR_RO_A,
      mra_pkg::AR_RO_B:    rif.allow = !rif.write;
      default:             rif.allow = 1'b0;
    endcase
    if (rif.fetch && rif.cfg.no_fetch_flag) begin
      rif.allow = 1'b0;
    end
  end

  // attribute decode; shareability and policy are informative only
  always_comb begin
    rif.mem_type  = mra_pkg::MRA_MT_RESERVED;
    rif.share     = 1'b0;
    rif.inner_pol = mra_pkg::POL_NC;
    rif.outer_pol = mra_pkg::POL_NC;
    if (rif.cfg.type_ext_field[2]) begin
      rif.mem_type  = mra_pkg::MRA_MT_NORMAL;
      rif.share     = rif.cfg.share;
      rif.outer_pol = rif.cfg.type_ext_field[1:0];
      rif.inner_pol = {rif.cfg.cache, rif.cfg.buff};
    end else begin
      case (rif.cfg.type_ext_field)
        mra_pkg::TYP_BASE: begin
          if (rif.cfg.cache) begin
            rif.mem_type  = mra_pkg::MRA_MT_NORMAL;
            rif.share     = rif.cfg.share;
            rif.inner_pol = mra_pkg::POL_WT_NWA;
            rif.outer_pol = mra_pkg::POL_WT_NWA;
          end else begin
            rif.share    = 1'b1;
            rif.mem_type = rif.cfg.buff ? mra_pkg::MRA_MT_DEVICE
                                        : mra_pkg::MRA_MT_STRONG;
          end
        end
        mra_pkg::TYP_NORMAL: begin
          if (rif.cfg.cache == rif.cfg.buff) begin
            rif.mem_type  = mra_pkg::MRA_MT_NORMAL;
            rif.share     = rif.cfg.share;
            rif.inner_pol = rif.cfg.cache ? mra_pkg::POL_WB_RWA : mra_pkg::POL_NC;
            rif.outer_pol = rif.inner_pol;
          end
        end
        mra_pkg::TYP_DEVICE: begin
          if (!rif.cfg.cache && !rif.cfg.buff) begin
            rif.mem_type = mra_pkg::MRA_MT_DEVICE;
          end
        end
        default: rif.mem_type = mra_pkg::MRA_MT_RESERVED;
      endcase
    end
    rif.reserved = (rif.mem_type == mra_pkg::MRA_MT_RESERVED);
  end
endmodule

// *** rtl/mra_top.sv ***
// Purpose: region attribute decode and permission check for eight protection regions
// Assumes: core presents one access per cycle at most; verdict one cycle later
// Notes:   shareability and cache policy are passed out but steer nothing here
module mra_top (
  input  wire logic        clk_in,                     // core clock, 20 MHz
  input  wire logic        rst_n_in,                   // async reset, active low
  input  wire logic        mpu_enable_in,              // checking on
  input  wire logic        bg_enable_in,               // privileged default map allowed
  input  wire logic        cfg_wr_in,                  // write one region's settings
  input  wire logic [2:0]  cfg_region_in,              // region to write or read back
  input  wire logic        cfg_enable_in,              // region enable
  input  wire logic [26:0] cfg_base_in,                // base address bits 31:5
  input  wire logic [4:0]  cfg_size_in,                // region is 2^(size+1) bytes
  input  wire logic [7:0]  cfg_subregion_off_mask_in,  // one bit per disabled eighth
  input  wire logic [2:0]  cfg_type_ext_field_in,      // type extension
  input  wire logic        cfg_share_in,               // sharing bit
  input  wire logic        cfg_cache_in,               // caching bit
  input  wire logic        cfg_buff_in,                // buffering bit
  input  wire logic [2:0]  cfg_access_rights_code_in,  // access rights code
  input  wire logic        cfg_no_fetch_flag_in,       // forbid instruction fetch
  input  wire logic        acc_valid_in,               // access request
  input  wire logic [31:0] acc_addr_in,                // access address
  input  wire logic        acc_write_in,               // 1 write, 0 read
  input  wire logic        acc_priv_in,                // privileged access
  input  wire logic        acc_fetch_in,               // instruction fetch
  input  wire logic [7:0]  cause_clear_in,             // write-one-to-clear cause bits
  output logic [26:0]      cfg_rd_base_out,            // read back base of cfg_region_in
  output logic [2:0]       cfg_rd_rights_out,          // read back rights of cfg_region_in
  output logic             resp_valid_out,             // verdict ready, one cycle pulse
  output logic             resp_fault_out,             // memory management fault pulse
  output logic             resp_region_hit_out,        // some region matched
  output logic [2:0]       resp_region_out,            // winning region number
  output logic [1:0]       resp_mem_type_out,          // decoded memory type
  output logic             resp_share_out,             // decoded shareability
  output logic [1:0]       resp_inner_pol_out,         // inner cache policy
  output logic [1:0]       resp_outer_pol_out,         // outer cache policy
  output logic             resp_attr_reserved_out,     // reserved attribute encoding
  output logic [7:0]       memfault_cause_reg_out,     // sticky fault cause
  output logic [31:0]      fault_addr_out              // address of last data fault
);
  localparam int unsigned NREG = mra_pkg::NUM_REGIONS;

  // region settings storage
  mra_pkg::mra_region_cfg_t cfg_q [NREG];
  mra_pkg::mra_region_cfg_t cfg_d [NREG];

  // per-region verdicts gathered into plain arrays
  logic                   hit_vec   [NREG];
  logic                   allow_vec [NREG];
  mra_pkg::mra_mem_type_t type_vec  [NREG];
  logic                   share_vec [NREG];
  logic [1:0]             inner_vec [NREG];
  logic [1:0]             outer_vec [NREG];
  logic                   rsvd_vec  [NREG];

  // winner of the overlap resolution
  logic                   win_hit;
  logic [2:0]             win_num;
  logic                   win_allow;
  mra_pkg::mra_mem_type_t win_type;
  logic                   win_share;
  logic [1:0]             win_inner;
  logic [1:0]             win_outer;
  logic                   win_rsvd;
  logic                   deny;

  // registered response
  logic                   valid_q,  valid_d;
  logic                   fault_q,  fault_d;
  logic                   hit_q,    hit_d;
  logic [2:0]             region_q, region_d;
  mra_pkg::mra_mem_type_t type_q,   type_d;
  logic                   share_q,  share_d;
  logic [1:0]             inner_q,  inner_d;
  logic [1:0]             outer_q,  outer_d;
  logic                   rsvd_q,   rsvd_d;
  logic [7:0]             memfault_cause_q, memfault_cause_d;
  logic [31:0]            fault_addr_q, fault_addr_d;
  logic [7:0]             cause_set;

  // one evaluator per region, all looking at the same access
  mra_region_if rif [NREG] ();

  for (genvar g = 0; g < NREG; g++) begin : g_region
    assign rif[g].cfg   = cfg_q[g];
    assign rif[g].addr  = acc_addr_in;
    assign rif[g].write = acc_write_in;
    assign rif[g].priv  = acc_priv_in;
    assign rif[g].fetch = acc_fetch_in;

    mra_region_eval u_eval (
      .rif (rif[g])
    );

    assign hit_vec[g]   = rif[g].hit;
    assign allow_vec[g] = rif[g].allow;
    assign type_vec[g]  = rif[g].mem_type;
    assign share_vec[g] = rif[g].share;
    assign inner_vec[g] = rif[g].inner_pol;
    assign outer_vec[g] = rif[g].outer_pol;
    assign rsvd_vec[g]  = rif[g].reserved;
  end

  // settings write port; a write lands at the next edge
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (cfg_wr_in) begin
      cfg_d[cfg_region_in].enable             = cfg_enable_in;
      cfg_d[cfg_region_in].base               = cfg_base_in;
      cfg_d[cfg_region_in].size               = cfg_size_in;
      cfg_d[cfg_region_in].subregion_off_mask = cfg_subregion_off_mask_in;
      cfg_d[cfg_region_in].type_ext_field     = cfg_type_ext_field_in;
      cfg_d[cfg_region_in].share              = cfg_share_in;
      cfg_d[cfg_region_in].cache              = cfg_cache_in;
      cfg_d[cfg_region_in].buff               = cfg_buff_in;
      cfg_d[cfg_region_in].access_rights_code = cfg_access_rights_code_in;
      cfg_d[cfg_region_in].no_fetch_flag      = cfg_no_fetch_flag_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NREG; i++) begin
        cfg_q[i] <= mra_pkg::REGION_RESET;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // read back straight from storage
  always_comb begin
    cfg_rd_base_out   = cfg_q[cfg_region_in].base;
    cfg_rd_rights_out = cfg_q[cfg_region_in].access_rights_code;
  end

  // overlap resolution: ascending scan so the highest hit is the last kept
  always_comb begin
    win_hit   = 1'b0;
    win_num   = '0;
    win_allow = 1'b0;
    win_type  = mra_pkg::MRA_MT_NORMAL;
    win_share = 1'b0;
    win_inner = mra_pkg::POL_NC;
    win_outer = mra_pkg::POL_NC;
    win_rsvd  = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      if (hit_vec[i]) begin
        win_hit   = 1'b1;
        win_num   = i[2:0];
        win_allow = allow_vec[i];
        win_type  = type_vec[i];
        win_share = share_vec[i];
        win_inner = inner_vec[i];
        win_outer = outer_vec[i];
        win_rsvd  = rsvd_vec[i];
      end
    end
    // no cover at all: only privileged code with the default map may pass
    if (win_hit) begin
      deny = !win_allow;
    end else begin
      deny = !(acc_priv_in && bg_enable_in);
    end
  end

  // response and fault bookkeeping
  always_comb begin
    valid_d   = acc_valid_in;
    fault_d   = acc_valid_in && mpu_enable_in && deny;
    hit_d     = hit_q;
    region_d  = region_q;
    type_d    = type_q;
    share_d   = share_q;
    inner_d   = inner_q;
    outer_d   = outer_q;
    rsvd_d    = rsvd_q;
    cause_set = '0;
    fault_addr_d = fault_addr_q;
    if (acc_valid_in) begin
      // with checking off every access passes as plain normal memory
      hit_d    = mpu_enable_in && win_hit;
      region_d = win_num;
      type_d   = mpu_enable_in ? win_type : mra_pkg::MRA_MT_NORMAL;
      share_d  = mpu_enable_in && win_share;
      inner_d  = mpu_enable_in ? win_inner : mra_pkg::POL_NC;
      outer_d  = mpu_enable_in ? win_outer : mra_pkg::POL_NC;
      rsvd_d   = mpu_enable_in && win_hit && win_rsvd;
    end
    if (fault_d) begin
      if (acc_fetch_in) begin
        cause_set[mra_pkg::CAUSE_FETCH] = 1'b1;
      end else begin
        cause_set[mra_pkg::CAUSE_DATA]     = 1'b1;
        cause_set[mra_pkg::CAUSE_ADDR_VLD] = 1'b1;
        fault_addr_d = acc_addr_in;
      end
    end
    // a cause arriving with its clear is kept
    memfault_cause_d = (memfault_cause_q & ~cause_clear_in) | cause_set;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_q          <= 1'b0;
      fault_q          <= 1'b0;
      hit_q            <= 1'b0;
      region_q         <= '0;
      type_q           <= mra_pkg::MRA_MT_NORMAL;
      share_q          <= 1'b0;
      inner_q          <= mra_pkg::POL_NC;
      outer_q          <= mra_pkg::POL_NC;
      rsvd_q           <= 1'b0;
      memfault_cause_q <= mra_pkg::CAUSE_RESET;
      fault_addr_q     <= '0;
    end else begin
      valid_q          <= valid_d;
      fault_q          <= fault_d;
      hit_q            <= hit_d;
      region_q         <= region_d;
      type_q           <= type_d;
      share_q          <= share_d;
      inner_q          <= inner_d;
      outer_q          <= outer_d;
      rsvd_q           <= rsvd_d;
      memfault_cause_q <= memfault_cause_d;
      fault_addr_q     <= fault_addr_d;
    end
  end

  // response and fault outputs all come from flip-flops
  assign resp_valid_out         = valid_q;
  assign resp_fault_out         = fault_q;
  assign resp_region_hit_out    = hit_q;
  assign resp_region_out        = region_q;
  assign resp_mem_type_out      = type_q;
  assign resp_share_out         = share_q;
  assign resp_inner_pol_out     = inner_q;
  assign resp_outer_pol_out     = outer_q;
  assign resp_attr_reserved_out = rsvd_q;
  assign memfault_cause_reg_out = memfault_cause_q;
  assign fault_addr_out         = fault_addr_q;
endmodule

// *** verification/mra_props.sv ***
// Purpose: verdict timing and fault cause checks at the ports of mra_top
// Assumes: one clock, async active-low reset
// Notes:   per-region permissions are judged by the bench, not here
module mra_props (
  input wire logic        clk_in,                 // clock
  input wire logic        rst_n_in,               // reset
  input wire logic        mpu_enable_in,          // checking on
  input wire logic        acc_valid_in,           // access
  input wire logic [31:0] acc_addr_in,            // address
  input wire logic        acc_fetch_in,           // fetch
  input wire logic [7:0]  cause_clear_in,         // clear mask
  input wire logic        resp_valid_out,         // verdict
  input wire logic        resp_fault_out,         // fault
  input wire logic        resp_region_hit_out,    // hit
  input wire logic [1:0]  resp_mem_type_out,      // type
  input wire logic        resp_attr_reserved_out, // reserved
  input wire logic [7:0]  memfault_cause_reg_out, // cause
  input wire logic [31:0] fault_addr_out          // fault address
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // verdict exactly one cycle after each access, never otherwise
  verdict_lat_a: assert property (acc_valid_in |=> resp_valid_out)
    else $error("verdict missing");
  no_spurious_a: assert property (!acc_valid_in |=> !resp_valid_out)
    else $error("verdict without access");
  fault_qual_a: assert property (resp_fault_out |-> resp_valid_out)
    else $error("fault outside verdict");
  // checking off: no fault, no hit, normal memory
  off_quiet_a: assert property (acc_valid_in && !mpu_enable_in |=>
    !resp_fault_out && !resp_region_hit_out && resp_mem_type_out == 2'h2)
    else $error("fault or hit while checking off");
  data_cause_a: assert property (resp_fault_out && !$past(acc_fetch_in) |->
    memfault_cause_reg_out[1] && memfault_cause_reg_out[7]
    && fault_addr_out == $past(acc_addr_in))
    else $error("data fault not recorded");
  fetch_cause_a: assert property (resp_fault_out && $past(acc_fetch_in) |->
    memfault_cause_reg_out[0])
    else $error("fetch fault not recorded");
  cause_sticky_a: assert property (memfault_cause_reg_out[1] && !cause_clear_in[1] |=>
    memfault_cause_reg_out[1])
    else $error("cause bit lost");
  cause_clear_a: assert property (cause_clear_in[0] && !acc_valid_in |=>
    !memfault_cause_reg_out[0])
    else $error("cause bit not cleared");
  // memory type stands between accesses
  attr_hold_a: assert property (!acc_valid_in |=> $stable(resp_mem_type_out))
    else $error("attributes moved while idle");
  rsv_flag_a: assert property (resp_valid_out && resp_mem_type_out == 2'h3 |->
    resp_attr_reserved_out)
    else $error("reserved type not flagged");

  cover property (resp_fault_out && memfault_cause_reg_out[0]);
  cover property (resp_valid_out && resp_attr_reserved_out);
  cover property (acc_valid_in ##1 acc_valid_in);
endmodule

bind mra_top mra_props u_props (.clk_in, .rst_n_in, .mpu_enable_in, .acc_valid_in,
  .acc_addr_in, .acc_fetch_in, .cause_clear_in, .resp_valid_out, .resp_fault_out,
  .resp_region_hit_out, .resp_mem_type_out, .resp_attr_reserved_out,
  .memfault_cause_reg_out, .fault_addr_out);

// *** verification/mra_core_model.sv ***
// Purpose: processor core issuing accesses into the checker
// Assumes: called at a falling edge
// Notes:   released qualifiers turn to their inverse so stale values never match
module mra_core_model (
  input  wire logic  clk_in,    // core clock
  output logic       valid_out, // access request
  output logic [31:0] addr_out, // address
  output logic       write_out, // write when high
  output logic       priv_out,  // privileged
  output logic       fetch_out  // instruction fetch
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_out = 1'b0;
    addr_out = 32'h0;
    write_out = 1'b0;
    priv_out = 1'b0;
    fetch_out = 1'b0;
  end
  // one access, held across one rising edge; back to back when called again
  task automatic issue(input logic [31:0] a, input logic w, p, f);
    valid_out = 1'b1;
    addr_out = a;
    write_out = w;
    priv_out = p;
    fetch_out = f;
    @(negedge clk_in);
  endtask
  // release the request for one cycle
  task automatic idle();
    valid_out = 1'b0;
    addr_out = ~addr_out;
    write_out = ~write_out;
    priv_out = ~priv_out;
    fetch_out = ~fetch_out;
    @(negedge clk_in);
  endtask
endmodule

// *** verification/test_mra_top.sv ***
// Purpose: self-checking bench for mra_top
// Assumes: inputs change at the falling edge
// Notes:   rights 100 expected to deny, as the designer chose
module test_mra_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_n_in, mpu_enable_in, bg_enable_in, cfg_wr_in;
  logic [2:0] cfg_region_in, cfg_rd_rights_out, resp_region_out;
  logic [7:0] cause_clear_in, memfault_cause_reg_out;
  logic acc_valid_in, acc_write_in, acc_priv_in, acc_fetch_in;
  logic [31:0] acc_addr_in, fault_addr_out;
  logic [26:0] cfg_rd_base_out;
  logic resp_valid_out, resp_fault_out, resp_region_hit_out, resp_share_out;
  logic resp_attr_reserved_out;
  logic [1:0] resp_mem_type_out, resp_inner_pol_out, resp_outer_pol_out;
  mra_pkg::mra_region_cfg_t cfg;
  int n_fail, num_checks;
  // type ext, s c b, type, share, inner, outer, reserved
  logic [13:0] attr_tab [12] = '{
    {3'h0, 3'b000, 2'h0, 1'b1, 4'h0, 1'b0},
    {3'h0, 3'b101, 2'h1, 1'b1, 4'h0, 1'b0},
    {3'h0, 3'b010, 2'h2, 1'b0, 2'h2, 2'h2, 1'b0},
    {3'h0, 3'b110, 2'h2, 1'b1, 2'h2, 2'h2, 1'b0},
    {3'h0, 3'b111, 2'h2, 1'b1, 2'h2, 2'h2, 1'b0},
    {3'h1, 3'b100, 2'h2, 1'b1, 2'h0, 2'h0, 1'b0},
    {3'h1, 3'b011, 2'h2, 1'b0, 2'h1, 2'h1, 1'b0},
    {3'h1, 3'b001, 2'h3, 1'b0, 4'h0, 1'b1},
    {3'h2, 3'b100, 2'h1, 1'b0, 4'h0, 1'b0},
    {3'h2, 3'b011, 2'h3, 1'b0, 4'h0, 1'b1},
    {3'h6, 3'b101, 2'h2, 1'b1, 2'h1, 2'h2, 1'b0},
    {3'h5, 3'b011, 2'h2, 1'b0, 2'h3, 2'h1, 1'b0}};

  mra_top u_dut (.clk_in, .rst_n_in, .mpu_enable_in, .bg_enable_in, .cfg_wr_in,
    .cfg_region_in, .cfg_enable_in(cfg.enable), .cfg_base_in(cfg.base),
    .cfg_size_in(cfg.size), .cfg_subregion_off_mask_in(cfg.subregion_off_mask),
    .cfg_type_ext_field_in(cfg.type_ext_field), .cfg_share_in(cfg.share),
    .cfg_cache_in(cfg.cache), .cfg_buff_in(cfg.buff),
    .cfg_access_rights_code_in(cfg.access_rights_code),
    .cfg_no_fetch_flag_in(cfg.no_fetch_flag), .acc_valid_in, .acc_addr_in,
    .acc_write_in, .acc_priv_in, .acc_fetch_in, .cause_clear_in, .cfg_rd_base_out,
    .cfg_rd_rights_out, .resp_valid_out, .resp_fault_out, .resp_region_hit_out,
    .resp_region_out, .resp_mem_type_out, .resp_share_out, .resp_inner_pol_out,
    .resp_outer_pol_out, .resp_attr_reserved_out, .memfault_cause_reg_out,
    .fault_addr_out);
  mra_core_model m (.clk_in, .valid_out(acc_valid_in), .addr_out(acc_addr_in),
    .write_out(acc_write_in), .priv_out(acc_priv_in), .fetch_out(acc_fetch_in));

  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // write one region, then read its base and rights back
  task automatic wcfg(input logic [2:0] r, input mra_pkg::mra_region_cfg_t c);
    cfg_region_in = r;
    cfg = c;
    cfg_wr_in = 1'b1;
    @(negedge clk_in);
    cfg_wr_in = 1'b0;
    chk(cfg_rd_rights_out, c.access_rights_code);
    chk(cfg_rd_base_out, c.base);
    // let an edge pass so a following write strobe is a fresh pulse
    @(negedge clk_in);
  endtask
  task automatic acc(input logic [31:0] a, input logic w, p, f, flt);
    m.issue(a, w, p, f);
    chk(resp_valid_out, 1'b1);
    chk(resp_fault_out, flt);
  endtask
  // expected denial per rights code, privilege and direction
  function automatic logic deny(input logic [2:0] ar, input logic p, w);
    case (ar)
      3'h1: return !p;
      3'h2: return w && !p;
      3'h3: return 1'b0;
      3'h5: return w || !p;
      3'h6, 3'h7: return w;
      default: return 1'b1;
    endcase
  endfunction

  task automatic t_perm();
    for (int a = 0; a < 8; a++) begin
      wcfg(3'h0, '{1'b1, 27'h0, 5'h0b, 8'h00, 3'h0, 1'b0, 1'b1, 1'b0, a[2:0], 1'b0});
      for (int j = 0; j < 4; j++) acc(32'h40, j[0], j[1], 1'b0, deny(a[2:0], j[1], j[0]));
      m.idle();
    end
  endtask
  task automatic t_attr();
    logic [13:0] e;
    for (int i = 0; i < 12; i++) begin
      e = attr_tab[i];
      wcfg(3'h0, '{1'b1, 27'h0, 5'h0b, 8'h00, e[13:11], e[10], e[9], e[8], 3'h3, 1'b0});
      acc(32'h80, 1'b0, 1'b1, 1'b0, 1'b0);
      chk(resp_mem_type_out, e[7:6]);
      chk(resp_attr_reserved_out, e[0]);
      if (!e[0]) chk(resp_share_out, e[5]);
      if (e[7:6] == 2'h2) chk({resp_inner_pol_out, resp_outer_pol_out}, e[4:1]);
      m.idle();
    end
  endtask
  task automatic t_overlap();
    wcfg(3'h0, '{1'b1, 27'h0, 5'h0b, 8'h00, 3'h0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0});
    wcfg(3'h1, '{1'b1, 27'h0, 5'h09, 8'h00, 3'h0, 1'b0, 1'b1, 1'b0, 3'h3, 1'b0});
    wcfg(3'h2, '{1'b1, 27'h80, 5'h07, 8'h01, 3'h0, 1'b0, 1'b1, 1'b0, 3'h3, 1'b0});
    acc(32'h100, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(resp_region_out, 3'h1);
    acc(32'h800, 1'b1, 1'b0, 1'b0, 1'b1);
    acc(32'h1000, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h1020, 1'b0, 1'b0, 1'b0, 1'b0);
    bg_enable_in = 1'b1;
    acc(32'h1000, 1'b0, 1'b1, 1'b0, 1'b0);
    chk(resp_region_hit_out, 1'b0);
    acc(32'h1000, 1'b0, 1'b0, 1'b0, 1'b1);
    bg_enable_in = 1'b0;
    m.idle();
  endtask
  task automatic t_fetch();
    wcfg(3'h3, '{1'b1, 27'h100, 5'h0b, 8'h00, 3'h0, 1'b0, 1'b1, 1'b0, 3'h3, 1'b1});
    acc(32'h2000, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(32'h2004, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(32'h844, 1'b1, 1'b1, 1'b0, 1'b1);
    chk(fault_addr_out, 32'h844);
    m.idle();
    cause_clear_in = 8'h01;
    @(negedge clk_in);
    cause_clear_in = 8'h00;
    chk(memfault_cause_reg_out, 8'h82);
    mpu_enable_in = 1'b0;
    acc(32'h44, 1'b1, 1'b0, 1'b0, 1'b0);
    m.idle();
    mpu_enable_in = 1'b1;
  endtask

  // 20 MHz core clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // bounded run, a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end
  initial begin
    rst_n_in = 1'b0;
    mpu_enable_in = 1'b1;
    bg_enable_in = 1'b0;
    cfg_wr_in = 1'b0;
    cfg_region_in = 3'h0;
    cfg = '0;
    cause_clear_in = 8'h00;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk(resp_mem_type_out, 2'h2);
    chk(memfault_cause_reg_out, 8'h00);
    t_perm();
    t_attr();
    t_overlap();
    t_fetch();
    finish_test();
  end
endmodule
